// File: hdl/jtti_map.vh
// constants for the test access port: instruction codes, widths, state bits
`ifndef JTTI_MAP_VH
`define JTTI_MAP_VH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JTTI_IR_W 16
`define JTTI_IR_CAPTURE 16'h0001
`define JTTI_OP_EXTEST 16'h0000
`define JTTI_OP_SAMPLE 16'h0002
`define JTTI_OP_IDCODE 16'h0004
`define JTTI_OP_BYPASS 16'hFFFF
`define JTTI_OP_FL_CTL 16'h0082
`define JTTI_OP_FL_DAT 16'h0083
`define JTTI_OP_FL_ADR 16'h0084

// ----------------------------------------------------------------------
// data register widths and identification capture value
// ----------------------------------------------------------------------
`define JTTI_BSR_W 134
`define JTTI_ID_W 32
`define JTTI_FL_CTL_W 8
`define JTTI_FL_DAT_W 8
`define JTTI_FL_ADR_W 16
`define JTTI_FL_CTL_WR_BIT 0
`define JTTI_FL_CTL_RD_BIT 1
// identification value is arbitrary; bit 0 stays one
`define JTTI_IDCODE_VAL 32'h1234_5671

// ----------------------------------------------------------------------
// tap controller states, one-hot codes
// ----------------------------------------------------------------------
`define JTTI_ST_W 16
`define JTTI_ST_RESET 16'h0001
`define JTTI_ST_IDLE 16'h0002
`define JTTI_ST_SEL_DR 16'h0004
`define JTTI_ST_CAP_DR 16'h0008
`define JTTI_ST_SH_DR 16'h0010
`define JTTI_ST_EX1_DR 16'h0020
`define JTTI_ST_PA_DR 16'h0040
`define JTTI_ST_EX2_DR 16'h0080
`define JTTI_ST_UPD_DR 16'h0100
`define JTTI_ST_SEL_IR 16'h0200
`define JTTI_ST_CAP_IR 16'h0400
`define JTTI_ST_SH_IR 16'h0800
`define JTTI_ST_EX1_IR 16'h1000
`define JTTI_ST_PA_IR 16'h2000
`define JTTI_ST_EX2_IR 16'h4000
`define JTTI_ST_UPD_IR 16'h8000

`endif

// File: hdl/jtti_tap_fsm.v
// tap controller state machine, advanced once per test clock rising edge
`timescale 1ns/1ps
`include "jtti_map.vh"

module jtti_tap_fsm (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // step enable and mode select sample
  input wire step,
  input wire tms,
  // state
  output reg [`JTTI_ST_W-1:0] state_q
);

  reg [`JTTI_ST_W-1:0] state_d;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      `JTTI_ST_RESET: state_d = tms ? `JTTI_ST_RESET : `JTTI_ST_IDLE;
      `JTTI_ST_IDLE: state_d = tms ? `JTTI_ST_SEL_DR : `JTTI_ST_IDLE;
      `JTTI_ST_SEL_DR: state_d = tms ? `JTTI_ST_SEL_IR : `JTTI_ST_CAP_DR;
      `JTTI_ST_CAP_DR: state_d = tms ? `JTTI_ST_EX1_DR : `JTTI_ST_SH_DR;
      `JTTI_ST_SH_DR: state_d = tms ? `JTTI_ST_EX1_DR : `JTTI_ST_SH_DR;
      `JTTI_ST_EX1_DR: state_d = tms ? `JTTI_ST_UPD_DR : `JTTI_ST_PA_DR;
      `JTTI_ST_PA_DR: state_d = tms ? `JTTI_ST_EX2_DR : `JTTI_ST_PA_DR;
      `JTTI_ST_EX2_DR: state_d = tms ? `JTTI_ST_UPD_DR : `JTTI_ST_SH_DR;
      `JTTI_ST_UPD_DR: state_d = tms ? `JTTI_ST_SEL_DR : `JTTI_ST_IDLE;
      `JTTI_ST_SEL_IR: state_d = tms ? `JTTI_ST_RESET : `JTTI_ST_CAP_IR;
      `JTTI_ST_CAP_IR: state_d = tms ? `JTTI_ST_EX1_IR : `JTTI_ST_SH_IR;
      `JTTI_ST_SH_IR: state_d = tms ? `JTTI_ST_EX1_IR : `JTTI_ST_SH_IR;
      `JTTI_ST_EX1_IR: state_d = tms ? `JTTI_ST_UPD_IR : `JTTI_ST_PA_IR;
      `JTTI_ST_PA_IR: state_d = tms ? `JTTI_ST_EX2_IR : `JTTI_ST_PA_IR;
      `JTTI_ST_EX2_IR: state_d = tms ? `JTTI_ST_UPD_IR : `JTTI_ST_SH_IR;
      `JTTI_ST_UPD_IR: state_d = tms ? `JTTI_ST_SEL_DR : `JTTI_ST_IDLE;
      default: state_d = `JTTI_ST_RESET;
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= `JTTI_ST_RESET;
    end else if (step) begin
      state_q <= state_d;
    end
  end

endmodule // jtti_tap_fsm

// File: hdl/jtti_scan_reg.v
// capture / shift / update scan register, shifts toward bit 0
`timescale 1ns/1ps
`include "jtti_map.vh"

module jtti_scan_reg #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control, each qualified by a test clock edge
  input wire capture,
  input wire shift,
  input wire update,
  // data
  input wire si,
  input wire [W-1:0] cap_val,
  output reg [W-1:0] sr_q,
  output reg [W-1:0] upd_q
);

  // ----------------------------------------------------------------------
  // shift stage and parallel hold stage
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sr_q <= RST_VAL;
      upd_q <= RST_VAL;
    end else begin
      if (capture) begin
        sr_q <= cap_val;
      end else if (shift) begin
        sr_q <= {si, sr_q[W-1:1]};
      end
      if (update) begin
        upd_q <= sr_q;
      end
    end
  end

endmodule // jtti_scan_reg

// File: hdl/jtti_tap.v
// test access port: pin sampling, instruction decode, data registers, serial out
`timescale 1ns/1ps
`include "jtti_map.vh"

module jtti_tap #(
  parameter BSR_W = `JTTI_BSR_W,
  parameter CORE_W = 8,
  parameter [`JTTI_ID_W-1:0] IDCODE = `JTTI_IDCODE_VAL
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // test pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_q,
  output reg tdo_oe_q,
  // boundary cells
  input wire [BSR_W-1:0] bsr_cap_in,
  output reg [BSR_W-1:0] bsr_pin_q,
  output reg bsr_drive_q,
  // inputs toward on-chip logic
  input wire [CORE_W-1:0] core_pin_in,
  output reg [CORE_W-1:0] core_in_q,
  // flash access port
  output reg [`JTTI_FL_ADR_W-1:0] flash_addr_q,
  output reg [`JTTI_FL_DAT_W-1:0] flash_wdata_q,
  output reg flash_wr_q,
  output reg flash_rd_q,
  input wire [`JTTI_FL_DAT_W-1:0] flash_rdata
);

  // ----------------------------------------------------------------------
  // pin synchronisers and test clock edge detection
  // ----------------------------------------------------------------------
  reg [2:0] tck_q;
  reg [1:0] tms_q;
  reg [1:0] tdi_q;
  reg [CORE_W-1:0] core_s1_q;
  reg [CORE_W-1:0] core_s2_q;
  wire tck_rise;
  wire tck_fall;

  always @(posedge clk) begin
    if (sys_rst) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h3;
      core_s1_q <= {CORE_W{1'b0}};
      core_s2_q <= {CORE_W{1'b0}};
    end else begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
      core_s1_q <= core_pin_in;
      core_s2_q <= core_s1_q;
    end
  end

  // edges seen on the second and third stages only
  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];

  // ----------------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------------
  wire [`JTTI_ST_W-1:0] st;

  jtti_tap_fsm u_fsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(tck_rise),
    .tms(tms_q[1]),
    .state_q(st)
  );

  wire in_reset = st[0];
  wire cap_dr = tck_rise & st[3];
  wire sh_dr = tck_rise & st[4];
  wire upd_dr = tck_rise & st[8];
  wire cap_ir = tck_rise & st[10];
  wire sh_ir = tck_rise & st[11];
  wire upd_ir = tck_rise & st[15];
  wire shifting = st[4] | st[11];

  // ----------------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------------
  wire [`JTTI_IR_W-1:0] ir_sr;
  reg [`JTTI_IR_W-1:0] ir_q;

  jtti_scan_reg #(
    .W(`JTTI_IR_W),
    .RST_VAL(`JTTI_IR_CAPTURE)
  ) u_ir (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_ir),
    .shift(sh_ir),
    .update(1'b0),
    .si(tdi_q[1]),
    .cap_val(`JTTI_IR_CAPTURE),
    .sr_q(ir_sr),
    .upd_q()
  );

  // test-logic-reset selects the identification register
  always @(posedge clk) begin
    if (sys_rst) begin
      ir_q <= `JTTI_OP_IDCODE;
    end else if (in_reset) begin
      ir_q <= `JTTI_OP_IDCODE;
    end else if (upd_ir) begin
      ir_q <= ir_sr;
    end
  end

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  localparam SEL_BSR = 3'd0;
  localparam SEL_ID = 3'd1;
  localparam SEL_BYP = 3'd2;
  localparam SEL_FCTL = 3'd3;
  localparam SEL_FDAT = 3'd4;
  localparam SEL_FADR = 3'd5;

  reg [2:0] sel;
  reg extest;

  always @* begin
    extest = 1'b0;
    case (ir_q)
      `JTTI_OP_EXTEST: begin
        sel = SEL_BSR;
        extest = 1'b1;
      end
      `JTTI_OP_SAMPLE: sel = SEL_BSR;
      `JTTI_OP_IDCODE: sel = SEL_ID;
      `JTTI_OP_BYPASS: sel = SEL_BYP;
      `JTTI_OP_FL_CTL: sel = SEL_FCTL;
      `JTTI_OP_FL_DAT: sel = SEL_FDAT;
      `JTTI_OP_FL_ADR: sel = SEL_FADR;
      default: sel = SEL_BYP;
    endcase
  end

  wire sel_bsr = (sel == SEL_BSR);
  wire sel_id = (sel == SEL_ID);
  wire sel_byp = (sel == SEL_BYP);
  wire sel_fctl = (sel == SEL_FCTL);
  wire sel_fdat = (sel == SEL_FDAT);
  wire sel_fadr = (sel == SEL_FADR);

  // ----------------------------------------------------------------------
  // boundary, identification and bypass registers
  // ----------------------------------------------------------------------
  wire [BSR_W-1:0] bsr_sr;
  wire [BSR_W-1:0] bsr_upd;
  wire [`JTTI_ID_W-1:0] id_sr;
  reg byp_q;

  // sample/preload captures and presets; the hold stage always feeds bsr_pin_q, and bsr_drive_q is set only under extest
  jtti_scan_reg #(
    .W(BSR_W)
  ) u_bsr (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_dr & sel_bsr),
    .shift(sh_dr & sel_bsr),
    .update(upd_dr & sel_bsr),
    .si(tdi_q[1]),
    .cap_val(bsr_cap_in),
    .sr_q(bsr_sr),
    .upd_q(bsr_upd)
  );

  jtti_scan_reg #(
    .W(`JTTI_ID_W)
  ) u_id (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_dr & sel_id),
    .shift(sh_dr & sel_id),
    .update(1'b0),
    .si(tdi_q[1]),
    .cap_val(IDCODE),
    .sr_q(id_sr),
    .upd_q()
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      byp_q <= 1'b0;
    end else if (cap_dr & sel_byp) begin
      byp_q <= 1'b0;
    end else if (sh_dr & sel_byp) begin
      byp_q <= tdi_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // flash access registers
  // ----------------------------------------------------------------------
  wire [`JTTI_FL_CTL_W-1:0] flash_access_control_reg;
  wire [`JTTI_FL_CTL_W-1:0] fctl_sr;
  wire [`JTTI_FL_DAT_W-1:0] flash_access_data_reg;
  wire [`JTTI_FL_DAT_W-1:0] fdat_sr;
  wire [`JTTI_FL_ADR_W-1:0] flash_access_address_reg;
  wire [`JTTI_FL_ADR_W-1:0] fadr_sr;
  reg [`JTTI_FL_DAT_W-1:0] rdata_q;

  jtti_scan_reg #(
    .W(`JTTI_FL_CTL_W)
  ) u_fctl (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_dr & sel_fctl),
    .shift(sh_dr & sel_fctl),
    .update(upd_dr & sel_fctl),
    .si(tdi_q[1]),
    .cap_val(flash_access_control_reg),
    .sr_q(fctl_sr),
    .upd_q(flash_access_control_reg)
  );

  jtti_scan_reg #(
    .W(`JTTI_FL_DAT_W)
  ) u_fdat (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_dr & sel_fdat),
    .shift(sh_dr & sel_fdat),
    .update(upd_dr & sel_fdat),
    .si(tdi_q[1]),
    .cap_val(rdata_q),
    .sr_q(fdat_sr),
    .upd_q(flash_access_data_reg)
  );

  jtti_scan_reg #(
    .W(`JTTI_FL_ADR_W)
  ) u_fadr (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(cap_dr & sel_fadr),
    .shift(sh_dr & sel_fadr),
    .update(upd_dr & sel_fadr),
    .si(tdi_q[1]),
    .cap_val(flash_access_address_reg),
    .sr_q(fadr_sr),
    .upd_q(flash_access_address_reg)
  );

  wire ctl_wr = flash_access_control_reg[`JTTI_FL_CTL_WR_BIT];
  wire ctl_rd = flash_access_control_reg[`JTTI_FL_CTL_RD_BIT];

  // read fetched on capture of the data register, write issued on
  // update of the data register; the control register gates both
  always @(posedge clk) begin
    if (sys_rst) begin
      flash_wr_q <= 1'b0;
      flash_rd_q <= 1'b0;
      flash_addr_q <= {`JTTI_FL_ADR_W{1'b0}};
      flash_wdata_q <= {`JTTI_FL_DAT_W{1'b0}};
      rdata_q <= {`JTTI_FL_DAT_W{1'b0}};
    end else begin
      flash_wr_q <= upd_dr & sel_fdat & ctl_wr;
      flash_rd_q <= cap_dr & sel_fdat & ctl_rd;
      flash_addr_q <= flash_access_address_reg;
      flash_wdata_q <= fdat_sr;
      if (flash_rd_q) begin
        rdata_q <= flash_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin control and core input forcing
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      bsr_pin_q <= {BSR_W{1'b0}};
      bsr_drive_q <= 1'b0;
      core_in_q <= {CORE_W{1'b1}};
    end else begin
      bsr_pin_q <= bsr_upd;
      bsr_drive_q <= extest;
      core_in_q <= extest ? {CORE_W{1'b1}} : core_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // serial output, changes on the test clock falling edge
  // ----------------------------------------------------------------------
  reg so;

  always @* begin
    if (st[11]) begin
      so = ir_sr[0];
    end else begin
      case (sel)
        SEL_BSR: so = bsr_sr[0];
        SEL_ID: so = id_sr[0];
        SEL_FCTL: so = fctl_sr[0];
        SEL_FDAT: so = fdat_sr[0];
        SEL_FADR: so = fadr_sr[0];
        default: so = byp_q;
      endcase
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= so;
      tdo_oe_q <= shifting;
    end
  end

endmodule // jtti_tap

// File: sim/jtti_tap_assertions.sv
// concurrent checks on the test access port outputs
`timescale 1ns/1ps
`include "jtti_map.vh"
module jtti_tap_assertions #(
  parameter BSR_W = `JTTI_BSR_W,
  parameter CORE_W = 8
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // test pins
  input wire tck,
  input wire tdo_q,
  input wire tdo_oe_q,
  // boundary and core side
  input wire [BSR_W-1:0] bsr_pin_q,
  input wire bsr_drive_q,
  input wire [CORE_W-1:0] core_pin_in,
  input wire [CORE_W-1:0] core_in_q,
  // flash side
  input wire [`JTTI_FL_ADR_W-1:0] flash_addr_q,
  input wire flash_wr_q,
  input wire flash_rd_q
);
  // ----
  // settle counter after reset
  // ----
  reg [3:0] up_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      up_q <= 4'h0;
    end else if (up_q != 4'h8) begin
      up_q <= up_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence held_test; bsr_drive_q [*2]; endsequence
  sequence held_func; !bsr_drive_q [*4]; endsequence
  reset_state_a: assert property ($fell(sys_rst) |-> !tdo_q && !tdo_oe_q && !bsr_drive_q
    && (&core_in_q) && bsr_pin_q == 0 && flash_addr_q == 0 && !flash_wr_q && !flash_rd_q)
    else $error("outputs off reset values");
  tdo_low_phase_a: assert property ($changed(tdo_q) |-> !tck)
    else $error("tdo moved while tck high");
  oe_low_phase_a: assert property ($changed(tdo_oe_q) |-> !tck)
    else $error("tdo enable moved while tck high");
  extest_force_a: assert property (held_test |-> &core_in_q)
    else $error("core inputs not forced high");
  core_follow_a: assert property (held_func ##0 (up_q == 4'h8)
    |-> core_in_q == $past(core_pin_in, 3)) else $error("core inputs not following pins");
  wr_pulse_a: assert property ($rose(flash_wr_q) |=> !flash_wr_q)
    else $error("write strobe too long");
  rd_pulse_a: assert property ($rose(flash_rd_q) |=> !flash_rd_q)
    else $error("read strobe too long");
  strobe_excl_a: assert property (!(flash_wr_q && flash_rd_q))
    else $error("read and write together");
  strobe_tck_a: assert property ($rose(flash_wr_q) || $rose(flash_rd_q) |-> tck && !tdo_oe_q)
    else $error("strobe outside update or capture");
  addr_hold_a: assert property (flash_wr_q || flash_rd_q |-> $stable(flash_addr_q))
    else $error("address moved during access");
endmodule // jtti_tap_assertions

bind jtti_tap jtti_tap_assertions #(.BSR_W(BSR_W), .CORE_W(CORE_W)) chk (.clk(clk),
  .sys_rst(sys_rst), .tck(tck), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .bsr_pin_q(bsr_pin_q),
  .bsr_drive_q(bsr_drive_q), .core_pin_in(core_pin_in), .core_in_q(core_in_q),
  .flash_addr_q(flash_addr_q), .flash_wr_q(flash_wr_q), .flash_rd_q(flash_rd_q));

// File: sim/jtti_ctl_model.sv
// behavioural test controller on the four test pins
`timescale 1ns/1ps
module jtti_ctl_model (
  // clock
  input wire clk,
  // test pins
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo_q
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ----
  // one tck period of 8 clk, tdo taken at end of low phase
  // ----
  task step(input logic m, input logic d, input logic sh, output logic o);
    tms = m;
    tdi = sh ? d : ~tdi;
    repeat (4) @(negedge clk);
    o = tdo_q;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    tck = 1'b0;
  endtask
  // from idle: capture, n shifts, update, back to idle
  task scan(input logic ir, input int n, input logic [159:0] din, output logic [159:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, 1'b0, o);
    if (ir) step(1'b1, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
  endtask
endmodule // jtti_ctl_model

// File: sim/jtti_tap_tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
`include "jtti_map.vh"
module jtti_tap_tb;
  reg clk;
  reg sys_rst = 1'b1;
  wire tck, tms, tdi, tdo_q, tdo_oe_q, bsr_drive_q, flash_wr_q, flash_rd_q;
  reg [133:0] bsr_cap_in = '0;
  wire [133:0] bsr_pin_q;
  reg [7:0] core_pin_in = 8'h00;
  wire [7:0] core_in_q, flash_wdata_q;
  wire [15:0] flash_addr_q;
  reg [7:0] flash_rdata = 8'h00;
  int mismatches = 0;
  int checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int rd_base;
  int n, len;
  logic o;
  logic [7:0] wr_seen;
  logic [31:0] seed = 32'h0000_ac19;
  logic [159:0] din, dout;
  logic [15:0] ops [8];
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  jtti_tap uut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
    .tdo_oe_q(tdo_oe_q), .bsr_cap_in(bsr_cap_in), .bsr_pin_q(bsr_pin_q),
    .bsr_drive_q(bsr_drive_q), .core_pin_in(core_pin_in), .core_in_q(core_in_q),
    .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q), .flash_wr_q(flash_wr_q),
    .flash_rd_q(flash_rd_q), .flash_rdata(flash_rdata));
  jtti_ctl_model ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q));
  always @(negedge clk) core_pin_in <= core_pin_in + 8'h35;
  always @(posedge clk) begin
    if (flash_wr_q === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_seen <= flash_wdata_q;
    end
    if (flash_rd_q === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task rnd160(output logic [159:0] v);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      v[i*32 +: 32] = seed;
    end
  endtask
  function automatic int dr_len(input logic [15:0] op);
    case (op)
      `JTTI_OP_EXTEST, `JTTI_OP_SAMPLE: dr_len = `JTTI_BSR_W;
      `JTTI_OP_IDCODE: dr_len = `JTTI_ID_W;
      `JTTI_OP_FL_CTL, `JTTI_OP_FL_DAT: dr_len = 8;
      `JTTI_OP_FL_ADR: dr_len = `JTTI_FL_ADR_W;
      default: dr_len = 1;
    endcase
  endfunction
  task check(input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task load_ir(input logic [15:0] op);
    ctl.scan(1'b1, 16, 160'(op), dout);
    check(160'(dout[15:0]), 160'(`JTTI_IR_CAPTURE));
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end
  // ----
  // scenarios
  // ----
  initial begin
    ops = '{`JTTI_OP_EXTEST, `JTTI_OP_SAMPLE, `JTTI_OP_IDCODE, `JTTI_OP_BYPASS,
      `JTTI_OP_FL_CTL, `JTTI_OP_FL_DAT, `JTTI_OP_FL_ADR, 16'h5a5a};
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    ctl.step(1'b0, 1'b0, 1'b0, o);
    rnd160(din);
    ctl.scan(1'b0, 64, din, dout);
    check(160'(dout[31:0]), 160'(`JTTI_IDCODE_VAL));
    check(160'(dout[63:32]), 160'(din[31:0]));
    foreach (ops[k]) begin
      load_ir(ops[k]);
      check(160'(bsr_drive_q), 160'(ops[k] == `JTTI_OP_EXTEST));
      if (ops[k] == `JTTI_OP_EXTEST) check(160'(&core_in_q), 160'(1));
      rnd160(din);
      bsr_cap_in = din[133:0] ^ din[159:26];
      len = dr_len(ops[k]);
      ctl.scan(1'b0, 160, din, dout);
      check(dout >> len, din & ({160{1'b1}} >> len));
      if (len == `JTTI_BSR_W) begin
        check(160'(dout[133:0]), 160'(bsr_cap_in));
        check(160'(bsr_pin_q), 160'(din[159:26]));
      end
      if (len == 1) check(160'(dout[0]), 160'(0));
      if (len == 16) check(160'(flash_addr_q), 160'(din[159:144]));
    end
    load_ir(`JTTI_OP_FL_CTL);
    ctl.scan(1'b0, 8, 160'(8'h01), dout);
    load_ir(`JTTI_OP_FL_DAT);
    n = wr_cnt;
    rd_base = rd_cnt;
    ctl.scan(1'b0, 8, 160'(8'h3c), dout);
    check(160'(wr_cnt - n), 160'(1));
    check(160'(rd_cnt - rd_base), 160'(0));
    check(160'(wr_seen), 160'(8'h3c));
    load_ir(`JTTI_OP_FL_CTL);
    ctl.scan(1'b0, 8, 160'(8'h02), dout);
    load_ir(`JTTI_OP_FL_DAT);
    n = wr_cnt;
    rd_base = rd_cnt;
    rnd160(din);
    flash_rdata = din[7:0];
    ctl.scan(1'b0, 8, 160'(8'h00), dout);
    ctl.scan(1'b0, 8, 160'(8'h00), dout);
    check(160'(dout[7:0]), 160'(din[7:0]));
    check(160'(wr_cnt - n), 160'(0));
    check(160'(rd_cnt - rd_base), 160'(2));
    for (int w = 0; w < 2; w++) begin
      load_ir(`JTTI_OP_BYPASS);
      if (w == 0) begin
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
      end else begin
        repeat (5) ctl.step(1'b1, 1'b0, 1'b0, o);
      end
      ctl.step(1'b0, 1'b0, 1'b0, o);
      ctl.scan(1'b0, 32, din, dout);
      check(160'(dout[31:0]), 160'(`JTTI_IDCODE_VAL));
    end
    report_and_stop();
  end
endmodule // jtti_tap_tb
